/* include/ssp_pkg.sv */
`default_nettype none
package ssp_pkg;
    localparam int        SSP_WIDTH          = 6;
    localparam int        SSP_REG_WIDTH      = 8;
    localparam logic [19:0] SSP_ADDR_DIR     = 20'hEE008;
    localparam logic [19:0] SSP_ADDR_DATA    = 20'hFFFD8;
    localparam logic [19:0] SSP_ADDR_SERCFG  = 20'hEE100;
    localparam logic [7:0]  SSP_RESET_DIR    = 8'hC0;
    localparam logic [7:0]  SSP_RESET_DATA   = 8'hC0;
    localparam logic [7:0]  SSP_RSVD_MASK    = 8'hC0;
    localparam logic [7:0]  SSP_WO_READ      = 8'hFF;
    localparam logic [1:0]  SSP_RESP_OKAY    = 2'h0;
    localparam logic [1:0]  SSP_RESP_SLVERR  = 2'h2;
    localparam int        SSP_PIN_TX0        = 0;
    localparam int        SSP_PIN_TX1        = 1;
    localparam int        SSP_PIN_RX0        = 2;
    localparam int        SSP_PIN_RX1        = 3;
    localparam int        SSP_PIN_CK0        = 4;
    localparam int        SSP_PIN_CK1        = 5;
    // Serial channel config register fields, one byte per channel
    localparam int        SSP_CFG_CKEN0      = 0;
    localparam int        SSP_CFG_CKEN1      = 1;
    localparam int        SSP_CFG_SYNC       = 2;
    localparam int        SSP_CFG_RXEN       = 3;
    localparam int        SSP_CFG_TXEN       = 4;
    localparam int        SSP_CFG_SMART      = 5;
    localparam int        SSP_CFG_CH1_BASE   = 8;
    localparam int        SSP_CFG_INTEN_A    = 16;
    localparam int        SSP_CFG_INTEN_B    = 17;
    localparam logic [31:0] SSP_CFG_MASK     = 32'h00033F3F;
    typedef enum logic [1:0] {
        SSP_IDLE  = 2'b00,
        SSP_RESP  = 2'b01
    } ssp_bus_state_t;
endpackage
`default_nettype wire

/* rtl/ssp_pinmux.sv */
`timescale 1ns/100ps
`default_nettype none
module ssp_pinmux
    import ssp_pkg::*;
(
    input  wire logic [5:0]  port_direction,
    input  wire logic [5:0]  port_output_data,
    input  wire logic [31:0] sercfg,
    input  wire logic        serial0_clock_out,
    input  wire logic        serial1_clock_out,
    input  wire logic        serial0_transmit_out,
    input  wire logic        serial1_transmit_out,
    output logic      [5:0]  pin_out,
    output logic      [5:0]  pin_oe,
    output logic      [5:0]  generic_pin
);
    // Decode of one channel's function select bits
    function automatic logic [3:0] ch_sel(input logic [5:0] c);
        logic ck_in;
        logic ck_out;
        logic rx;
        logic tx;
        ck_in  = c[SSP_CFG_CKEN1];
        ck_out = !c[SSP_CFG_CKEN1] && (c[SSP_CFG_SYNC] || c[SSP_CFG_CKEN0]);
        rx     = c[SSP_CFG_RXEN] || c[SSP_CFG_SMART];
        tx     = c[SSP_CFG_TXEN] || c[SSP_CFG_SMART];
        return {ck_in, ck_out, rx, tx};
    endfunction

    logic [3:0] s0;
    logic [3:0] s1;
    logic [5:0] alt_oe;
    logic [5:0] alt_in;
    logic [5:0] alt_val;

    // No operating-mode input here; muxing is fixed across modes
    always_comb begin
        s0 = ch_sel(sercfg[5:0]);
        s1 = ch_sel(sercfg[SSP_CFG_CH1_BASE +: 6]);
        alt_oe  = '0;
        alt_in  = '0;
        alt_val = '0;
        alt_oe[SSP_PIN_CK1]  = s1[2];
        alt_in[SSP_PIN_CK1]  = s1[3];
        alt_val[SSP_PIN_CK1] = serial1_clock_out;
        alt_oe[SSP_PIN_CK0]  = s0[2];
        alt_in[SSP_PIN_CK0]  = s0[3];
        alt_val[SSP_PIN_CK0] = serial0_clock_out;
        alt_in[SSP_PIN_RX1]  = s1[1];
        alt_in[SSP_PIN_RX0]  = s0[1];
        alt_oe[SSP_PIN_TX1]  = s1[0];
        alt_val[SSP_PIN_TX1] = serial1_transmit_out;
        alt_oe[SSP_PIN_TX0]  = s0[0];
        alt_val[SSP_PIN_TX0] = serial0_transmit_out;
        generic_pin = ~(alt_oe | alt_in);
        // Generic pins drive data when direction bit is one
        pin_oe  = alt_oe | (generic_pin & port_direction);
        pin_out = (alt_oe & alt_val) | (~alt_oe & port_output_data);
    end
endmodule
`default_nettype wire

/* rtl/ssp_port.sv */
// How it works
// - Six two-way pins shared with two serial channels and two interrupt inputs.
// - Interrupt inputs sample their pins whenever enabled, whatever the direction.
// - Pin muxing is the same in every operating mode.
// - Direction bit one makes a generic pin output, zero input.
// - Direction register is write-only and reads back as all ones.
// - Direction bits 7 and 6 reserved, unwritable, read as one.
// - Direction resets to C0 on reset and hardware standby, kept in software standby.
// - In software standby output pins keep driving their level.
// - Generic output pins drive the data register bit.
// - Data read returns stored bit where direction is one.
// - Data read returns live pin level where direction is zero.
// - Data bits 7 and 6 reserved, ignore writes, read as one.
// - Data resets to C0 on reset and hardware standby, kept in software standby.
// - Pin 5: channel 1 clock input, clock output, or generic by enables.
// - Pin 4: channel 0 clock input, clock output, or generic by enables.
// - Pin 3: channel 1 receive when receive or smart-card set, else generic.
// - Pin 1: channel 1 transmit when transmit or smart-card set, else generic.
// - Pin 0: channel 0 transmit when transmit or smart-card set, else generic.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module ssp_port
    import ssp_pkg::*;
#(
    parameter int ADDR_WIDTH = 20
) (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  hw_standby,
    input  wire logic                  sw_standby,
    input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input  wire logic [2:0]            s_axi_awprot,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic      [1:0]            s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input  wire logic [2:0]            s_axi_arprot,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic      [31:0]           s_axi_rdata,
    output logic      [1:0]            s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic [5:0]            pin_in,
    output logic      [5:0]            pin_out,
    output logic      [5:0]            pin_oe,
    input  wire logic                  serial0_clock_out,
    input  wire logic                  serial1_clock_out,
    input  wire logic                  serial0_transmit_out,
    input  wire logic                  serial1_transmit_out,
    output logic                       serial0_clock_pin,
    output logic                       serial1_clock_pin,
    output logic                       serial0_receive_pin,
    output logic                       serial1_receive_pin,
    output logic                       ext_interrupt_request_a,
    output logic                       ext_interrupt_request_b
);
    // ------------------------------------------------------------
    // Registers and pin sampling
    // ------------------------------------------------------------
    logic [7:0]       port_direction;
    logic [7:0]       port_output_data;
    logic [31:0]      sercfg;
    logic [5:0]       pin_sync;
    logic [5:0]       mux_out;
    logic [5:0]       mux_oe;
    logic [5:0]       generic_pin;
    logic [5:0]       held_out;
    logic [5:0]       held_oe;
    logic             in_sw_standby;
    ssp_bus_state_t   wr_state;
    ssp_bus_state_t   rd_state;
    logic             aw_held;
    logic             w_held;
    logic [ADDR_WIDTH-1:0] aw_addr;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             wr_fire;
    logic [7:0]       data_read;

    ssp_sync #(
        .WIDTH    (SSP_WIDTH)
    ) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (pin_in),
        .sync_out (pin_sync)
    );

    ssp_pinmux u_mux (
        .port_direction       (port_direction[5:0]),
        .port_output_data     (port_output_data[5:0]),
        .sercfg               (sercfg),
        .serial0_clock_out    (serial0_clock_out),
        .serial1_clock_out    (serial1_clock_out),
        .serial0_transmit_out (serial0_transmit_out),
        .serial1_transmit_out (serial1_transmit_out),
        .pin_out              (mux_out),
        .pin_oe               (mux_oe),
        .generic_pin          (generic_pin)
    );

    // ------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------
    assign s_axi_awready = (wr_state == SSP_IDLE) && !aw_held;
    assign s_axi_wready  = (wr_state == SSP_IDLE) && !w_held;
    assign wr_fire = (wr_state == SSP_IDLE)
                   && (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= '0;
            w_data  <= '0;
            w_strb  <= '0;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
        end
    end

    logic [ADDR_WIDTH-1:0] wa;
    logic [31:0]           wd;
    logic [3:0]            ws;
    assign wa = aw_held ? aw_addr : s_axi_awaddr;
    assign wd = w_held ? w_data : s_axi_wdata;
    assign ws = w_held ? w_strb : s_axi_wstrb;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state     <= SSP_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= SSP_RESP_OKAY;
        end else if (wr_fire) begin
            wr_state     <= SSP_RESP;
            s_axi_bvalid <= 1'b1;
            if ((wa == SSP_ADDR_DIR) || (wa == SSP_ADDR_DATA) || (wa == SSP_ADDR_SERCFG)) begin
                s_axi_bresp <= SSP_RESP_OKAY;
            end else begin
                s_axi_bresp <= SSP_RESP_SLVERR;
            end
        end else if (s_axi_bvalid && s_axi_bready) begin
            wr_state     <= SSP_IDLE;
            s_axi_bvalid <= 1'b0;
        end
    end

    // Hardware standby acts like reset; software standby only freezes pins
    always_ff @(posedge aclk) begin
        if (!aresetn || hw_standby) begin
            port_direction   <= SSP_RESET_DIR;
            port_output_data <= SSP_RESET_DATA;
        end else if (wr_fire && ws[0]) begin
            if (wa == SSP_ADDR_DIR) begin
                port_direction <= wd[7:0] | SSP_RSVD_MASK;
            end else if (wa == SSP_ADDR_DATA) begin
                port_output_data <= wd[7:0] | SSP_RSVD_MASK;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || hw_standby) begin
            sercfg <= '0;
        end else if (wr_fire && (wa == SSP_ADDR_SERCFG)) begin
            for (int i = 0; i < 4; i++) begin
                if (ws[i]) begin
                    sercfg[i*8 +: 8] <= wd[i*8 +: 8] & SSP_CFG_MASK[i*8 +: 8];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------
    // Pins read live where direction is zero, else stored data
    assign data_read = {2'b11, (port_direction[5:0] & port_output_data[5:0])
                              | (~port_direction[5:0] & pin_sync)};

    assign s_axi_arready = (rd_state == SSP_IDLE);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state     <= SSP_IDLE;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= SSP_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rd_state     <= SSP_RESP;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= SSP_RESP_OKAY;
            if (s_axi_araddr == SSP_ADDR_DIR) begin
                s_axi_rdata <= {24'h000000, SSP_WO_READ};
            end else if (s_axi_araddr == SSP_ADDR_DATA) begin
                s_axi_rdata <= {24'h000000, data_read};
            end else if (s_axi_araddr == SSP_ADDR_SERCFG) begin
                s_axi_rdata <= sercfg;
            end else begin
                s_axi_rdata <= '0;
                s_axi_rresp <= SSP_RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            rd_state     <= SSP_IDLE;
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Pin drive and standby hold
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_sw_standby <= 1'b0;
            held_out      <= '0;
            held_oe       <= '0;
        end else begin
            in_sw_standby <= sw_standby && !hw_standby;
            if (!in_sw_standby) begin
                held_out <= mux_out;
                held_oe  <= mux_oe;
            end
        end
    end

    // Frozen copy keeps outputs driven through software standby
    assign pin_out = in_sw_standby ? held_out : mux_out;
    assign pin_oe  = hw_standby ? 6'h00 : (in_sw_standby ? held_oe : mux_oe);

    // Inputs towards channels and interrupt logic
    assign serial0_clock_pin   = pin_sync[SSP_PIN_CK0];
    assign serial1_clock_pin   = pin_sync[SSP_PIN_CK1];
    assign serial0_receive_pin = pin_sync[SSP_PIN_RX0];
    assign serial1_receive_pin = pin_sync[SSP_PIN_RX1];
    // Sampled even when the pin drives out; user must take care
    assign ext_interrupt_request_a = sercfg[SSP_CFG_INTEN_A] & pin_sync[SSP_PIN_CK0];
    assign ext_interrupt_request_b = sercfg[SSP_CFG_INTEN_B] & pin_sync[SSP_PIN_CK1];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_DIR_RSVD: assert property (@(posedge aclk) disable iff (!aresetn)
        port_direction[7:6] == 2'b11) else $error("direction reserved bits lost");
    AST_DATA_RSVD: assert property (@(posedge aclk) disable iff (!aresetn)
        port_output_data[7:6] == 2'b11) else $error("data reserved bits lost");
    AST_DIR_READ: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == SSP_ADDR_DIR)
        |=> s_axi_rvalid && s_axi_rdata[7:0] == 8'hFF) else $error("direction read not ones");
    AST_HWSTBY: assert property (@(posedge aclk) disable iff (!aresetn)
        hw_standby |=> port_direction == SSP_RESET_DIR && port_output_data == SSP_RESET_DATA)
        else $error("hardware standby did not reload");
    AST_DIR_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && ws[0] && wa == SSP_ADDR_DIR && !hw_standby)
        |=> port_direction == ($past(wd[7:0]) | 8'hC0)) else $error("direction write lost");
    AST_GEN_OUT: assert property (@(posedge aclk) disable iff (!aresetn)
        (!in_sw_standby && !hw_standby && generic_pin[3] && port_direction[3])
        |-> pin_oe[3] && pin_out[3] == port_output_data[3]) else $error("generic out bad");
    AST_TX0: assert property (@(posedge aclk) disable iff (!aresetn)
        (!in_sw_standby && !hw_standby && sercfg[SSP_CFG_SMART])
        |-> pin_oe[0] && pin_out[0] == serial0_transmit_out) else $error("tx0 mux bad");
    AST_CK1_IN: assert property (@(posedge aclk) disable iff (!aresetn)
        (!in_sw_standby && sercfg[SSP_CFG_CH1_BASE + SSP_CFG_CKEN1])
        |-> !pin_oe[5]) else $error("clock1 input driven");
    AST_STBY_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        (in_sw_standby && $past(in_sw_standby) && !hw_standby)
        |-> $stable(pin_out) && $stable(pin_oe)) else $error("standby pins moved");
    AST_READ_LIVE: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == SSP_ADDR_DATA && !port_direction[2])
        |=> s_axi_rdata[2] == $past(pin_sync[2])) else $error("live read bad");
    AST_BRESP: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire |=> s_axi_bvalid) else $error("no write response");

    COV_WRITE_DIR: cover property (@(posedge aclk) wr_fire && wa == SSP_ADDR_DIR);
    COV_READ_DATA: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
    COV_STANDBY: cover property (@(posedge aclk) in_sw_standby && |held_oe);
    COV_SMART: cover property (@(posedge aclk) sercfg[SSP_CFG_SMART] && pin_oe[0]);
endmodule
`default_nettype wire

/* rtl/ssp_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module ssp_sync
    import ssp_pkg::*;
#(
    parameter int WIDTH = 6
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    // First stage feeds only the second stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule
`default_nettype wire

/* test/ssp_board.sv */
`timescale 1ns/100ps
`default_nettype none
module ssp_board (
    input  wire logic [5:0] pin_out,
    input  wire logic [5:0] pin_oe,
    input  wire logic [5:0] board_level,
    output logic      [5:0] pin_in
);
    // ----
    // Wire level
    // ----
    // Board drives only released pins, so no contention to resolve
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : board_level[i];
        end
    end
endmodule
`default_nettype wire

/* test/ssp_port_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module ssp_port_tb
    import ssp_pkg::*;
;
    logic        aclk = 0, aresetn = 0, hw_standby = 0, sw_standby = 0;
    logic [19:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, resp;
    logic [5:0]  pin_in, pin_out, pin_oe, board_level = 6'h15;
    logic        ck0_o = 1, ck1_o = 1, tx0_o = 1, tx1_o = 1;
    logic        ck0_p, ck1_p, rx0_p, rx1_p, irq_a, irq_b;
    logic [31:0] rv;
    int          error_cnt = 0, n_tests = 0;
    localparam logic [31:0] MUX_TBL [12] = '{32'h00103F01, 32'h10003F02, 32'h00083B00,
        32'h08003700, 32'h00013F10, 32'h00022F00, 32'h00043F10, 32'h01003F20,
        32'h02001F00, 32'h04003F20, 32'h00203B01, 32'h20003702};

    always #2.5 aclk = ~aclk;

    ssp_port DUT (.aclk(aclk), .aresetn(aresetn), .hw_standby(hw_standby),
        .sw_standby(sw_standby), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .serial0_clock_out(ck0_o), .serial1_clock_out(ck1_o),
        .serial0_transmit_out(tx0_o), .serial1_transmit_out(tx1_o),
        .serial0_clock_pin(ck0_p), .serial1_clock_pin(ck1_p),
        .serial0_receive_pin(rx0_p), .serial1_receive_pin(rx1_p),
        .ext_interrupt_request_a(irq_a), .ext_interrupt_request_b(irq_b));

    ssp_board board (.pin_out(pin_out), .pin_oe(pin_oe), .board_level(board_level),
        .pin_in(pin_in));

    // ----
    // Reporting
    // ----
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tmo(input int n);
        if (n >= 100) begin
            error_cnt++;
            $display("BAD bus_wait exp answer seen none");
            final_report();
        end
    endtask

    // ----
    // Bus master
    // ----
    // No fixed latency assumed; every wait is bounded
    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        int   n;
        logic aw_ok, w_ok;
        n = 0;
        aw_ok = 0;
        w_ok = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(aw_ok && w_ok) && n < 100) begin
            @(posedge aclk);
            n++;
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1;
                awvalid <= 0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1;
                wvalid <= 0;
            end
        end
        tmo(n);
        while (bvalid !== 1'b1 && n < 200) begin
            @(posedge aclk);
            n++;
        end
        tmo(n - 100);
        resp = bresp;
        bready <= 0;
    endtask

    task automatic rd(input logic [19:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge aclk);
            n++;
        end while (arready !== 1'b1 && n < 100);
        arvalid <= 0;
        while (rvalid !== 1'b1 && n < 200) begin
            @(posedge aclk);
            n++;
        end
        tmo(n - 100);
        rv = rdata;
        resp = rresp;
        rready <= 0;
    endtask

    // ----
    // Scenarios
    // ----
    task automatic t_reset();
        rd(SSP_ADDR_DIR);
        chk("dir_read", rv, 32'h000000FF);
        rd(SSP_ADDR_DATA);
        chk("data_reset", rv, 32'h000000D5);
        chk("oe_reset", pin_oe, 6'h00);
    endtask

    task automatic t_out();
        wr(SSP_ADDR_DIR, 32'h0000003F);
        wr(SSP_ADDR_DATA, 32'h0000002A);
        chk("oe_out", pin_oe, 6'h3F);
        chk("pin_out", pin_out, 6'h2A);
        rd(SSP_ADDR_DATA);
        chk("data_rd", rv, 32'h000000EA);
        rd(SSP_ADDR_DIR);
        chk("dir_rsvd", rv, 32'h000000FF);
    endtask

    task automatic t_mix();
        wr(SSP_ADDR_DIR, 32'h0000000C);
        board_level <= 6'h33;
        repeat (4) @(posedge aclk);
        rd(SSP_ADDR_DATA);
        chk("data_mix", rv, 32'h000000FB);
        chk("ck1_pass", ck1_p, 1'b1);
    endtask

    task automatic t_bad();
        wr(20'hEE00C, 32'h00000000);
        chk("bad_wr", resp, SSP_RESP_SLVERR);
        rd(20'h00000);
        chk("bad_rd", resp, SSP_RESP_SLVERR);
    endtask

    // Each row: config, expected enables, expected driven levels
    task automatic t_mux();
        wr(SSP_ADDR_DIR, 32'h0000003F);
        wr(SSP_ADDR_DATA, 32'h00000000);
        for (int i = 0; i < 12; i++) begin
            wr(SSP_ADDR_SERCFG, {16'h0000, MUX_TBL[i][31:16]});
            chk("mux_oe", pin_oe, MUX_TBL[i][15:8]);
            chk("mux_out", pin_out & pin_oe, MUX_TBL[i][7:0]);
        end
        // Pin 1 driven high by the channel, yet read returns stored zero
        rd(SSP_ADDR_DATA);
        chk("data_stored", rv, 32'h000000C0);
        wr(SSP_ADDR_SERCFG, 32'h00000000);
    endtask

    task automatic t_irq();
        wr(SSP_ADDR_DATA, 32'h00000010);
        wr(SSP_ADDR_SERCFG, 32'h00030000);
        repeat (4) @(posedge aclk);
        chk("irq_a", irq_a, 1'b1);
        chk("irq_b", irq_b, 1'b0);
        wr(SSP_ADDR_DATA, 32'h00000030);
        repeat (4) @(posedge aclk);
        chk("irq_b_on", irq_b, 1'b1);
        wr(SSP_ADDR_SERCFG, 32'h00000000);
        repeat (4) @(posedge aclk);
        chk("irq_a_off", irq_a, 1'b0);
    endtask

    task automatic t_stby();
        @(posedge aclk);
        sw_standby <= 1;
        repeat (3) @(posedge aclk);
        chk("sw_oe", pin_oe, 6'h3F);
        chk("sw_out", pin_out, 6'h30);
        // A data change while frozen must not reach the pins
        wr(SSP_ADDR_DATA, 32'h0000000F);
        chk("sw_frozen", pin_out, 6'h30);
        sw_standby <= 0;
        rd(SSP_ADDR_DATA);
        chk("sw_keep", rv, 32'h000000CF);
        @(posedge aclk);
        hw_standby <= 1;
        repeat (2) @(posedge aclk);
        chk("hw_oe", pin_oe, 6'h00);
        chk("hw_out", pin_out, 6'h00);
        hw_standby <= 0;
        repeat (4) @(posedge aclk);
        chk("hw_dir", pin_oe, 6'h00);
        rd(SSP_ADDR_DATA);
        chk("hw_data", rv, 32'h000000F3);
    endtask

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        t_reset();
        t_out();
        t_mix();
        t_bad();
        t_mux();
        t_irq();
        t_stby();
        final_report();
    end
endmodule
`default_nettype wire
